// ### rtl/clk_sel_pkg.sv
// shared constants and types for the port clock selection block
`default_nettype none
package clk_sel_pkg;
    // ---------------------------------------------------------------
    // register map (word offsets as byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ctrl_offset = 8'h00;      // clock source flags
    localparam logic [7:0] divisor_offset = 8'h04;   // rate divider divisor
    localparam logic [7:0] synth_offset_0 = 8'h08;   // synth word bits 31:0
    localparam logic [7:0] synth_offset_4 = 8'h18;   // synth word bits 131:128
    localparam logic [7:0] go_offset = 8'h1c;        // write starts the shift
    localparam logic [7:0] status_offset = 8'h20;    // live status
    // ---------------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------------
    localparam int ctrl_rx_rec_bit = 0;   // receiver from recovery loop
    localparam int ctrl_tx_rec_bit = 1;   // transmitter from recovery loop
    localparam int ctrl_tx_div_bit = 2;   // transmitter from divider
    localparam int ctrl_x8_bit = 3;       // reference at 8x data rate
    localparam int ctrl_x16_bit = 4;      // reference at 16x data rate
    localparam int ctrl_base_bit = 5;     // base clock select output level
    localparam int ctrl_width = 6;
    // ---------------------------------------------------------------
    // reset values and sizes
    // ---------------------------------------------------------------
    localparam logic [5:0] ctrl_reset = 6'h04;         // tx from divider, fixed base
    localparam logic [15:0] divisor_reset = 16'h0000;
    localparam int synth_bits = 132;                   // configuration word length
    localparam int synth_words = 5;
    localparam int spi_half_period = 4;                // base clocks per half serial clock
    localparam real base_clock_mhz = 14.7456;          // standard base source
    // ---------------------------------------------------------------
    // serial loader states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ld_idle_type = 3'b001,
        ld_low_type = 3'b010,
        ld_high_type = 3'b100
    } ld_state_type;
endpackage
`default_nettype wire

// ### rtl/rate_divider.sv
// rate divider: one-cycle pulse every divisor+1 base clocks
`default_nettype none
module rate_divider #(
    parameter int width = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [width-1:0] divisor,
    output logic tick
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [width-1:0] count; // counts down to zero
        logic tick;              // pulse at terminal count
    } div_state_type;
    div_state_type cur_ff;
    div_state_type nxt_cur;

    // next state: reload on zero gives divisor+1 period
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.tick = 1'b0;
        if (cur_ff.count == '0) begin
            nxt_cur.count = divisor;
            nxt_cur.tick = 1'b1;
        end else begin
            nxt_cur.count = cur_ff.count - 1'b1;
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign tick = cur_ff.tick;
endmodule
`default_nettype wire

// ### rtl/clock_recovery_loop.sv
// digital clock recovery: sample tick per bit from edges in receive data
`default_nettype none
module clock_recovery_loop (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ref_tick,      // reference pulse from rate divider
    input wire logic times_sixteen, // 1: 16 ticks per bit, 0: 8
    input wire logic rx_data,       // synchronised receive data
    output logic bit_tick           // one pulse per recovered bit
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0] phase; // position inside bit cell
        logic last_data;   // previous data level
        logic bit_tick;    // recovered clock pulse
    } rec_state_type;
    rec_state_type cur_ff;
    rec_state_type nxt_cur;
    logic [3:0] last_phase;
    logic [3:0] half_phase;

    // next state: edges realign phase to the cell edge, so drift up to
    // a tenth of the rate is absorbed between transitions
    always_comb begin
        last_phase = times_sixteen ? 4'hf : 4'h7;
        half_phase = times_sixteen ? 4'h8 : 4'h4;
        nxt_cur = cur_ff;
        nxt_cur.bit_tick = 1'b0;
        if (ref_tick) begin
            nxt_cur.last_data = rx_data;
            if (rx_data != cur_ff.last_data) begin
                // transition: resynchronise to cell edge
                nxt_cur.phase = 4'h1;
            end else if (cur_ff.phase >= last_phase) begin
                nxt_cur.phase = 4'h0;
            end else begin
                nxt_cur.phase = cur_ff.phase + 1'b1;
            end
            // sample point mid cell, free running without edges
            nxt_cur.bit_tick = (cur_ff.phase == half_phase);
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign bit_tick = cur_ff.bit_tick;
endmodule
`default_nettype wire

// ### rtl/port_clock_select.sv
// port clock selection, rate divider, recovery loop and synth loader
`default_nettype none
module port_clock_select (
    input wire logic ref_clk,                          // base clock
    input wire logic sys_rst,                          // synchronous, high
    input wire logic [7:0] addr,                       // register byte address
    input wire logic [31:0] wr_data,                   // write data
    input wire logic wr_en,                            // write strobe
    input wire logic rd_en,                            // read strobe
    output logic [31:0] rd_data,                       // read data, next cycle
    input wire logic rx_clk_pin,                       // external receive clock
    input wire logic rx_data_pin,                      // receive data line
    output logic rx_clk_tick,                          // receiver bit pulse
    output logic tx_clk_tick,                          // transmitter bit pulse
    output logic base_clock_select,                    // 0 fixed source, 1 synth
    output logic synth_sclk,                           // serial clock to synth
    output logic synth_mosi,                           // serial data to synth
    output logic synth_cs                              // select, high while loading
);
    import clk_sel_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rxc;  // receive clock pin stages
        logic [2:0] rxd;  // receive data pin stages
        logic rxc_q;      // filtered receive clock level
        logic rxd_q;      // filtered receive data level
    } sync_type;

    // ---------------------------------------------------------------
    // main state
    // ---------------------------------------------------------------
    typedef struct packed {
        sync_type sy;                      // pin sampling
        logic [ctrl_width-1:0] ctrl;       // clock source flags
        logic [15:0] divisor;              // rate divider divisor
        logic [synth_bits-1:0] synth_word; // configuration word
        logic [synth_bits-1:0] shift;      // word being shifted
        logic [7:0] bit_cnt;               // bits left to send
        logic [2:0] half_cnt;              // half serial period count
        ld_state_type ld;                  // loader state
        logic [31:0] rd_data;              // read data register
        logic rx_tick;                     // receiver clock pulse
        logic tx_tick;                     // transmitter clock pulse
        logic sclk;                        // serial clock out
        logic mosi;                        // serial data out
        logic cs;                          // select out
    } top_state_type;
    top_state_type cur_ff;
    top_state_type nxt_cur;

    logic div_tick;      // rate divider output pulse
    logic rec_tick;      // recovered bit pulse
    logic rxc_rise;      // external receive clock rising edge
    logic [31:0] rd_mux; // read value before registering

    // select one 32-bit word of the synth word, high word padded
    function automatic logic [31:0] synth_slice(input logic [synth_bits-1:0] w, input logic [2:0] i);
        logic [159:0] padded;
        padded = {28'h000_0000, w};
        synth_slice = padded[32*i +: 32];
    endfunction

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    rate_divider #(
        .width(16)
    ) u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .divisor(cur_ff.divisor),
        .tick(div_tick)
    );

    clock_recovery_loop u_rec (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ref_tick(div_tick),
        .times_sixteen(cur_ff.ctrl[ctrl_x16_bit] & ~cur_ff.ctrl[ctrl_x8_bit]),
        .rx_data(cur_ff.sy.rxd_q),
        .bit_tick(rec_tick)
    );

    // rising edge of the filtered external receive clock
    assign rxc_rise = (cur_ff.sy.rxc[2] == cur_ff.sy.rxc[1]) & cur_ff.sy.rxc[1] & ~cur_ff.sy.rxc_q;

    // ---------------------------------------------------------------
    // read multiplexer
    // ---------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            ctrl_offset: begin
                rd_mux = {26'h000_0000, cur_ff.ctrl};
            end
            divisor_offset: begin
                rd_mux = {16'h0000, cur_ff.divisor};
            end
            status_offset: begin
                // busy, live select and receive clock and data levels
                rd_mux = {28'h000_0000, cur_ff.sy.rxd_q, cur_ff.sy.rxc_q, cur_ff.ctrl[ctrl_base_bit], cur_ff.cs};
            end
            default: begin
                if (addr >= synth_offset_0 && addr <= synth_offset_4 && addr[1:0] == 2'b00) begin
                    rd_mux = synth_slice(cur_ff.synth_word, 3'(addr[7:2] - synth_offset_0[7:2]));
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        // synchronisers: stage 1 feeds only stage 2
        nxt_cur.sy.rxc = {cur_ff.sy.rxc[1:0], rx_clk_pin};
        nxt_cur.sy.rxd = {cur_ff.sy.rxd[1:0], rx_data_pin};
        if (cur_ff.sy.rxc[2] == cur_ff.sy.rxc[1]) begin
            nxt_cur.sy.rxc_q = cur_ff.sy.rxc[1];
        end
        if (cur_ff.sy.rxd[2] == cur_ff.sy.rxd[1]) begin
            nxt_cur.sy.rxd_q = cur_ff.sy.rxd[1];
        end

        // read data only in the cycle after the strobe
        nxt_cur.rd_data = rd_en ? rd_mux : 32'h0000_0000;

        // register writes
        if (wr_en) begin
            case (addr)
                ctrl_offset: begin
                    nxt_cur.ctrl = wr_data[ctrl_width-1:0];
                end
                divisor_offset: begin
                    nxt_cur.divisor = wr_data[15:0];
                end
                go_offset: begin
                    // start loading unless already busy
                    if (cur_ff.ld == ld_idle_type) begin
                        nxt_cur.shift = cur_ff.synth_word;
                        nxt_cur.bit_cnt = 8'(synth_bits);
                        nxt_cur.half_cnt = 3'h0;
                        nxt_cur.cs = 1'b1;
                        nxt_cur.sclk = 1'b0;
                        nxt_cur.mosi = cur_ff.synth_word[synth_bits-1];
                        nxt_cur.ld = ld_low_type;
                    end
                end
                default: begin
                    if (addr >= synth_offset_0 && addr <= synth_offset_4 && addr[1:0] == 2'b00) begin
                        for (int i = 0; i < synth_words; i++) begin
                            if (addr[7:2] - synth_offset_0[7:2] == 6'(i)) begin
                                if (i == synth_words - 1) begin
                                    nxt_cur.synth_word[synth_bits-1 -: 4] = wr_data[3:0];
                                end else begin
                                    nxt_cur.synth_word[32*i +: 32] = wr_data;
                                end
                            end
                        end
                    end
                end
            endcase
        end

        // synthesizer loader: msb first, data changes on falling edge
        case (cur_ff.ld)
            ld_idle_type: begin
                nxt_cur.sclk = 1'b0;
            end
            ld_low_type: begin
                if (cur_ff.half_cnt == 3'(spi_half_period - 1)) begin
                    nxt_cur.half_cnt = 3'h0;
                    nxt_cur.sclk = 1'b1;
                    nxt_cur.ld = ld_high_type;
                end else begin
                    nxt_cur.half_cnt = cur_ff.half_cnt + 1'b1;
                end
            end
            ld_high_type: begin
                if (cur_ff.half_cnt == 3'(spi_half_period - 1)) begin
                    nxt_cur.half_cnt = 3'h0;
                    nxt_cur.sclk = 1'b0;
                    nxt_cur.bit_cnt = cur_ff.bit_cnt - 1'b1;
                    nxt_cur.shift = {cur_ff.shift[synth_bits-2:0], 1'b0};
                    nxt_cur.mosi = cur_ff.shift[synth_bits-2];
                    if (cur_ff.bit_cnt == 8'h01) begin
                        nxt_cur.cs = 1'b0; // word complete
                        nxt_cur.mosi = 1'b0;
                        nxt_cur.ld = ld_idle_type;
                    end else begin
                        nxt_cur.ld = ld_low_type;
                    end
                end else begin
                    nxt_cur.half_cnt = cur_ff.half_cnt + 1'b1;
                end
            end
            default: begin
                nxt_cur.ld = ld_idle_type;
            end
        endcase

        // receiver clock: recovered or external pin
        nxt_cur.rx_tick = cur_ff.ctrl[ctrl_rx_rec_bit] ? rec_tick : rxc_rise;

        // transmitter clock: recovered wins over divider, else pin
        if (cur_ff.ctrl[ctrl_tx_rec_bit]) begin
            nxt_cur.tx_tick = rec_tick;
        end else if (cur_ff.ctrl[ctrl_tx_div_bit]) begin
            nxt_cur.tx_tick = div_tick;
        end else begin
            nxt_cur.tx_tick = rxc_rise;
        end
    end

    // ---------------------------------------------------------------
    // register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
            cur_ff.ctrl <= ctrl_reset;
            cur_ff.divisor <= divisor_reset;
            cur_ff.ld <= ld_idle_type;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from flip-flops
    assign rd_data = cur_ff.rd_data;
    assign rx_clk_tick = cur_ff.rx_tick;
    assign tx_clk_tick = cur_ff.tx_tick;
    assign base_clock_select = cur_ff.ctrl[ctrl_base_bit];
    assign synth_sclk = cur_ff.sclk;
    assign synth_mosi = cur_ff.mosi;
    assign synth_cs = cur_ff.cs;
endmodule
`default_nettype wire

// ### verif/port_clock_select_assertions.sv
// concurrent checks on the port clock selection block
`default_nettype none
module port_clock_select_checker
    import clk_sel_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rx_clk_pin,
    input wire logic rx_data_pin,
    input wire logic rx_clk_tick,
    input wire logic tx_clk_tick,
    input wire logic base_clock_select,
    input wire logic synth_sclk,
    input wire logic synth_mosi,
    input wire logic synth_cs
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ---------------------------------------------------------------
    // helper state
    // ---------------------------------------------------------------
    logic [10:0] cs_len_ff; // cycles with select high
    logic [7:0] rise_cnt_ff; // serial clock rises in this word
    logic sclk_q_ff; // serial clock one cycle back
    logic [5:0] ctrl_copy_ff; // copy of the last control write
    // count frame length and rises, shadow the control flags
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_len_ff <= 11'h000;
            rise_cnt_ff <= 8'h00;
            sclk_q_ff <= 1'b0;
            ctrl_copy_ff <= ctrl_reset;
        end else begin
            sclk_q_ff <= synth_sclk;
            cs_len_ff <= synth_cs ? cs_len_ff + 11'h001 : 11'h000;
            rise_cnt_ff <= !synth_cs ? 8'h00 : rise_cnt_ff + 8'(synth_sclk && !sclk_q_ff);
            if (wr_en && addr == ctrl_offset) begin
                ctrl_copy_ff <= wr_data[5:0];
            end
        end
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    ctrl_readback_a: assert property (rd_en && addr == ctrl_offset |=> rd_data == 32'(ctrl_copy_ff))
        else $error("control readback mismatch");
    base_select_a: assert property ($past(ctrl_copy_ff[ctrl_base_bit], 2) == ctrl_copy_ff[ctrl_base_bit]
        |-> base_clock_select == ctrl_copy_ff[ctrl_base_bit])
        else $error("base select pin does not follow control");
    go_starts_a: assert property (wr_en && addr == go_offset && !synth_cs |=> synth_cs)
        else $error("start write did not raise select");
    cs_length_a: assert property ($fell(synth_cs) |-> cs_len_ff == 11'h420)
        else $error("select length wrong");
    rise_count_a: assert property ($fell(synth_cs) |-> rise_cnt_ff == 8'h84)
        else $error("serial clock rise count wrong");
    sclk_high_a: assert property ($rose(synth_sclk) |-> synth_sclk [*4] ##1 !synth_sclk)
        else $error("serial clock high time wrong");
    sclk_in_frame_a: assert property (synth_sclk |-> synth_cs)
        else $error("serial clock outside frame");
    mosi_steady_a: assert property (synth_sclk |-> $stable(synth_mosi))
        else $error("serial data moved while clock high");
    idle_lines_a: assert property (!synth_cs |-> !synth_sclk && !synth_mosi)
        else $error("serial lines not idle low");
endmodule
bind port_clock_select port_clock_select_checker port_clock_select_checker_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin), .rx_clk_tick(rx_clk_tick),
    .tx_clk_tick(tx_clk_tick), .base_clock_select(base_clock_select), .synth_sclk(synth_sclk),
    .synth_mosi(synth_mosi), .synth_cs(synth_cs)
);
`default_nettype wire

// ### verif/serial_far_end.sv
// far end model: synthesizer shift receiver and remote line source
`default_nettype none
module serial_far_end (
    input wire logic ref_clk,
    input wire logic synth_sclk,
    input wire logic synth_mosi,
    input wire logic synth_cs,
    input wire logic clk_on,
    input wire logic data_on,
    input wire logic [15:0] bit_len,
    input wire logic [3:0] edge_every,
    output logic rx_clk_pin,
    output logic rx_data_pin,
    output logic [131:0] word_seen,
    output logic [7:0] bits_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_q = 1'b0; // serial clock one cycle back
    logic cs_q = 1'b0; // select one cycle back
    int cyc = 0; // position inside a line bit
    int bit_no = 0; // line bits sent
    // quiet line and empty word at start
    initial begin
        word_seen = '0;
        rx_data_pin = 1'b1;
    end
    // shift in on each serial clock rise, msb first; drive the line
    always @(posedge ref_clk) begin
        sclk_q <= synth_sclk;
        cs_q <= synth_cs;
        if (synth_cs && !cs_q) begin
            bits_seen <= 8'h00;
        end else if (synth_cs && synth_sclk && !sclk_q) begin
            word_seen <= {word_seen[130:0], synth_mosi};
            bits_seen <= bits_seen + 8'h01;
        end
        cyc <= (cyc + 1 >= bit_len) ? 0 : cyc + 1;
        if (cyc + 1 >= bit_len) begin
            bit_no <= bit_no + 1;
            // toggling every bit is the all-zero preamble in inverted NRZ
            if (data_on && (bit_no + 1) % edge_every == 0) begin
                rx_data_pin <= ~rx_data_pin;
            end
        end
        // line clock stands still when not in use
        rx_clk_pin <= clk_on && (cyc < bit_len / 2);
    end
endmodule
`default_nettype wire

// ### verif/port_clock_select_bench.sv
// self-checking bench for the port clock selection block
`default_nettype none
module port_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_sel_pkg::*;
    localparam int pin_len = 20; // line clock period in cycles
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic clk_on = 1'b0;
    logic data_on = 1'b0;
    logic [15:0] bit_len = 16'h0014;
    logic [3:0] edge_every = 4'h1;
    logic [31:0] seed = 32'hb24e_7d0d;
    logic [31:0] rd_data;
    logic rx_clk_pin, rx_data_pin, rx_clk_tick, tx_clk_tick;
    logic base_clock_select, synth_sclk, synth_mosi, synth_cs;
    logic [131:0] word_seen;
    logic [7:0] bits_seen;
    int n_fail = 0;
    int samples_checked = 0;
    port_clock_select port_clock_select_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin), .rx_clk_tick(rx_clk_tick),
        .tx_clk_tick(tx_clk_tick), .base_clock_select(base_clock_select), .synth_sclk(synth_sclk),
        .synth_mosi(synth_mosi), .synth_cs(synth_cs));
    serial_far_end serial_far_end_inst (
        .ref_clk(ref_clk), .synth_sclk(synth_sclk), .synth_mosi(synth_mosi), .synth_cs(synth_cs),
        .clk_on(clk_on), .data_on(data_on), .bit_len(bit_len), .edge_every(edge_every),
        .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin), .word_seen(word_seen), .bits_seen(bits_seen));
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected tick period for a flag set and divisor
    function automatic int exp_per(input logic [5:0] c, input int d, input bit tx);
        int n;
        n = (c[ctrl_x16_bit] && !c[ctrl_x8_bit]) ? 16 : 8;
        if (tx ? c[ctrl_tx_rec_bit] : c[ctrl_rx_rec_bit]) return n * (d + 1);
        if (tx && c[ctrl_tx_div_bit]) return d + 1;
        return pin_len;
    endfunction
    task automatic chk(input logic [131:0] got, input logic [131:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int exp, input int tol);
        samples_checked++;
        if (got > exp + tol || got < exp - tol) begin
            n_fail++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    // register bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
    // cycles from one tick to the next, bounded
    task automatic period(input bit tx, output int p);
        int n = 0;
        @(posedge ref_clk);
        #1;
        while ((tx ? tx_clk_tick : rx_clk_tick) !== 1'b1 && n < 5000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        p = 0;
        do begin
            @(posedge ref_clk);
            #1;
            p++;
        end while ((tx ? tx_clk_tick : rx_clk_tick) !== 1'b1 && p < 5000);
    endtask
    // receive ticks within a span, after settling
    task automatic count_ticks(input int cyc, output int n);
        n = 0;
        repeat (200) @(posedge ref_clk);
        repeat (cyc) begin
            @(posedge ref_clk);
            #1;
            if (rx_clk_tick === 1'b1) n++;
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #2_000_000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
    // main sequence
    initial begin
        logic [31:0] v;
        logic [159:0] w;
        logic [5:0] modes [5];
        int p, d;
        modes = '{6'h04, 6'h0b, 6'h17, 6'h19, 6'h00};
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(ctrl_offset, v);
        chk(v, ctrl_reset);
        rd(8'h44, v);
        chk(v, 32'h0000_0000);
        chk(base_clock_select, 1'b0);
        for (int b = 0; b < 2; b++) begin
            wr(ctrl_offset, 32'(ctrl_reset) | 32'(b << ctrl_base_bit));
            repeat (3) @(posedge ref_clk);
            chk(base_clock_select, b[0]);
            rd(status_offset, v);
            chk(v[1], b[0]);
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hffff_ffff : rnd();
            wr(divisor_offset, v);
            rd(divisor_offset, w[31:0]);
            chk(w[31:0], {16'h0000, v[15:0]});
        end
        wr(divisor_offset, 32'h0000_0000); // a full-range count already loaded must run out
        for (p = 0; p < 70000 && tx_clk_tick !== 1'b1; p++) @(posedge ref_clk);
        chk(tx_clk_tick, 1'b1);
        // five clock source combinations, divisor zero first then random and small
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 0 : int'(rnd() % 6);
            wr(divisor_offset, 32'(d));
            wr(ctrl_offset, 32'(modes[i]));
            clk_on <= !(modes[i][ctrl_rx_rec_bit] && (modes[i][ctrl_tx_rec_bit] || modes[i][ctrl_tx_div_bit]));
            for (int t = 0; t < 2; t++) begin
                period(t[0], p);
                period(t[0], p);
                chk_int(p, exp_per(modes[i], d, t[0]), 0);
            end
        end
        // recovery from a line six percent slow, then sparse edges
        wr(divisor_offset, 32'h0000_0001);
        wr(ctrl_offset, 32'h0000_0011);
        clk_on <= 1'b0;
        data_on <= 1'b1;
        bit_len <= 16'h0022;
        count_ticks(40 * 34, p);
        chk_int(p, 40, 2);
        bit_len <= 16'h0020;
        edge_every <= 4'h6;
        count_ticks(40 * 32, p);
        chk_int(p, 40, 2);
        data_on <= 1'b0;
        // two synthesizer loads, each with a start while busy
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < synth_words; k++) begin
                w[32 * k +: 32] = (k == 4) ? (rnd() & 32'h0000_000f) : rnd();
                wr(synth_offset_0 + 8'(4 * k), w[32 * k +: 32]);
            end
            wr(go_offset, 32'h0000_0000);
            rd(status_offset, v);
            chk(v[0], 1'b1);
            wr(go_offset, 32'h0000_0000);
            p = 0;
            while (synth_cs !== 1'b0 && p < 3000) begin
                @(posedge ref_clk);
                p++;
            end
            chk(synth_cs, 1'b0);
            chk(word_seen, w[131:0]);
            chk(bits_seen, 8'h84);
        end
        end_sim();
    end
endmodule
`default_nettype wire
